// ### verilog/port_a_upper_pin_function_mux.sv
`timescale 1ns/1ps
module port_a_upper_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter bit EXT_PWM_VARIANT = 1'b0,
  parameter bit HAS_ASYNC_B = 1'b1,
  parameter bit HAS_SYNC_B = 1'b1,
  parameter bit HAS_CAN_B = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic protected_write_enable_i,
  // Pads of pins 13, 14, 15 (index 0, 1, 2)
  input wire logic [2:0] pad_in_i,
  output logic [2:0] pad_out_o,
  output logic [2:0] pad_oe_o,
  // General-purpose I/O logic
  input wire logic [2:0] gpio_out_i,
  input wire logic [2:0] gpio_oe_i,
  output logic [2:0] gpio_in_o,
  // Trip zones 2, 3, 4
  output logic [2:0] trip_zone_in_o,
  // PWM outputs A of channels 14, 15, 16
  input wire logic pwm14_out_a_i,
  input wire logic pwm15_out_a_i,
  input wire logic pwm16_out_a_i,
  // Asynchronous serial port B
  output logic async_b_receive_o,
  input wire logic async_b_transmit_i,
  // CAN controller B
  output logic can_b_receive_o,
  // Synchronous serial port B: data out/in (0), clock (1), select (2)
  input wire logic [2:0] sync_b_out_i,
  input wire logic [2:0] sync_b_oe_i,
  output logic [2:0] sync_b_in_o
);

  logic [31:0] mux_select_reg;
  logic [1:0] pwm_mode_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [2:0] pad_meta_reg;
  logic [2:0] pad_sync_reg;
  logic [2:0] pad_out_reg;
  logic [2:0] pad_oe_reg;
  logic [2:0] gpio_in_reg;
  logic [2:0] trip_zone_reg;
  logic async_rx_reg;
  logic can_rx_reg;
  logic [2:0] sync_in_reg;

  logic write_allowed;
  logic pwm_active;
  logic [1:0] field [ROUTED_PINS];
  logic [3:0] src_out [ROUTED_PINS];
  logic [3:0] src_oe [ROUTED_PINS];
  logic [3:0] avail [ROUTED_PINS];
  logic [3:0] sel [ROUTED_PINS];
  logic [2:0] route_out;
  logic [2:0] route_oe;
  logic [2:0] pwm_a;

  // Register writes need the protected write enable
  assign write_allowed = wr_i && protected_write_enable_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mux_select_reg <= MUX_SELECT_RESET;
    end
    else if (write_allowed && addr_i == MUX_SELECT_OFS)
    begin
      mux_select_reg <= wr_data_i;
    end
  end

  // Mode register shares the same protection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_mode_reg <= PWM_MODE_RESET;
    end
    else if (write_allowed && addr_i == MUX_CONFIG_OFS)
    begin
      pwm_mode_reg <= wr_data_i[PWM_MODE_LSB +: PWM_MODE_W];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_reg <= READ_ZERO;
    end
    else if (rd_i)
    begin
      case (addr_i)
        MUX_SELECT_OFS: rd_data_reg <= mux_select_reg;
        MUX_CONFIG_OFS: rd_data_reg <= {30'h0000_0000, pwm_mode_reg};
        default: rd_data_reg <= READ_ZERO;
      endcase
    end
    else
    begin
      rd_data_reg <= READ_ZERO;
    end
  end

  // Pads are asynchronous to clk_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_meta_reg <= 3'h0;
      pad_sync_reg <= 3'h0;
    end
    else
    begin
      pad_meta_reg <= pad_in_i;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // Only 1,1 hands the pins to PWM; odd settings fall back to trip zones
  assign pwm_active = EXT_PWM_VARIANT && (pwm_mode_reg == PWM_MODE_PWM);

  assign field[0] = mux_select_reg[PIN13_LSB +: FIELD_W];
  assign field[1] = mux_select_reg[PIN14_LSB +: FIELD_W];
  assign field[2] = mux_select_reg[PIN15_LSB +: FIELD_W];
  assign pwm_a = {pwm16_out_a_i, pwm15_out_a_i, pwm14_out_a_i};

  // Pin 13 sources per code
  assign src_out[0] = {sync_b_out_i[0], 1'b0, pwm_a[0], gpio_out_i[0]};
  assign src_oe[0] = {sync_b_oe_i[0], 1'b0, pwm_active, gpio_oe_i[0]};
  assign avail[0] = {HAS_SYNC_B, HAS_CAN_B, 1'b1, 1'b1};

  // Pin 14 sources per code
  assign src_out[1] = {sync_b_out_i[1], async_b_transmit_i, pwm_a[1], gpio_out_i[1]};
  assign src_oe[1] = {sync_b_oe_i[1], 1'b1, pwm_active, gpio_oe_i[1]};
  assign avail[1] = {HAS_SYNC_B, HAS_ASYNC_B, 1'b1, 1'b1};

  // Pin 15 sources per code
  assign src_out[2] = {sync_b_out_i[2], 1'b0, pwm_a[2], gpio_out_i[2]};
  assign src_oe[2] = {sync_b_oe_i[2], 1'b0, pwm_active, gpio_oe_i[2]};
  assign avail[2] = {HAS_SYNC_B, HAS_ASYNC_B, 1'b1, 1'b1};

  genvar p;
  generate
    for (p = 0; p < ROUTED_PINS; p++)
    begin : g_pin
      pin_route_cell u_cell (
        .field_i(field[p]),
        .avail_i(avail[p]),
        .src_out_i(src_out[p]),
        .src_oe_i(src_oe[p]),
        .pad_out_o(route_out[p]),
        .pad_oe_o(route_oe[p]),
        .sel_o(sel[p])
      );

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pad_out_reg[p] <= 1'b0;
          pad_oe_reg[p] <= 1'b0;
          gpio_in_reg[p] <= 1'b0;
          trip_zone_reg[p] <= IDLE_INPUT;
          sync_in_reg[p] <= IDLE_INPUT;
        end
        else
        begin
          pad_out_reg[p] <= route_out[p];
          pad_oe_reg[p] <= route_oe[p];
          // General I/O input always follows the pin, as on a real port
          gpio_in_reg[p] <= pad_sync_reg[p];
          // Trip input only when code 01 does not carry PWM
          trip_zone_reg[p] <= (sel[p][1] && !pwm_active) ? pad_sync_reg[p]
                                                         : IDLE_INPUT;
          sync_in_reg[p] <= sel[p][3] ? pad_sync_reg[p] : IDLE_INPUT;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      async_rx_reg <= IDLE_INPUT;
      can_rx_reg <= IDLE_INPUT;
    end
    else
    begin
      async_rx_reg <= sel[2][2] ? pad_sync_reg[2] : IDLE_INPUT;
      can_rx_reg <= sel[0][2] ? pad_sync_reg[0] : IDLE_INPUT;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign pad_out_o = pad_out_reg;
  assign pad_oe_o = pad_oe_reg;
  assign gpio_in_o = gpio_in_reg;
  assign trip_zone_in_o = trip_zone_reg;
  assign async_b_receive_o = async_rx_reg;
  assign can_b_receive_o = can_rx_reg;
  assign sync_b_in_o = sync_in_reg;

  chk_write_blocked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && !protected_write_enable_i && addr_i == MUX_SELECT_OFS)
      |=> $stable(mux_select_reg))
    else $error("unprotected write changed mux register");

  chk_write_stored: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && protected_write_enable_i && addr_i == MUX_SELECT_OFS && !rd_i)
      ##1 (!wr_i && !rd_i)
      ##1 (rd_i && addr_i == MUX_SELECT_OFS && !wr_i)
      |=> rd_data_o == $past(wr_data_i, 3))
    else $error("mux register read back differs from write");

  chk_read_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> rd_data_o == READ_ZERO)
    else $error("read data not zero outside read cycle");

  chk_reset_gpio: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (mux_select_reg == MUX_SELECT_RESET) ##1 (pad_oe_o == gpio_oe_i))
    else $error("fields not general I/O after reset");

  chk_gpio_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (field[1] == CODE_GPIO) |=> pad_oe_o[1] == $past(gpio_oe_i[1])
      && pad_out_o[1] == $past(gpio_out_i[1]))
    else $error("pin 14 not following general I/O");

  chk_pin15_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (field[2] == CODE_SEL1 && !pwm_active)
      |=> !pad_oe_o[2] && trip_zone_in_o[2] == $past(pad_sync_reg[2]))
    else $error("pin 15 trip input not routed");

  chk_pin14_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (field[1] == CODE_SEL1 && !pwm_active)
      |=> !pad_oe_o[1] && trip_zone_in_o[1] == $past(pad_sync_reg[1]))
    else $error("pin 14 trip input not routed");

  chk_pin13_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (field[0] == CODE_SEL1 && !pwm_active)
      |=> !pad_oe_o[0] && trip_zone_in_o[0] == $past(pad_sync_reg[0]))
    else $error("pin 13 trip input not routed");

  chk_pin14_pwm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (EXT_PWM_VARIANT && pwm_mode_reg == PWM_MODE_PWM && field[1] == CODE_SEL1)
      |=> pad_oe_o[1] && pad_out_o[1] == $past(pwm15_out_a_i)
      && trip_zone_in_o[1] == IDLE_INPUT)
    else $error("pin 14 pwm output not routed");

  chk_pin13_pwm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (EXT_PWM_VARIANT && pwm_mode_reg == PWM_MODE_PWM && field[0] == CODE_SEL1)
      |=> pad_oe_o[0] && pad_out_o[0] == $past(pwm14_out_a_i)
      && trip_zone_in_o[0] == IDLE_INPUT)
    else $error("pin 13 pwm output not routed");

  chk_pin15_pwm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (EXT_PWM_VARIANT && pwm_mode_reg == PWM_MODE_PWM && field[2] == CODE_SEL1)
      |=> pad_oe_o[2] && pad_out_o[2] == $past(pwm16_out_a_i)
      && trip_zone_in_o[2] == IDLE_INPUT)
    else $error("pin 15 pwm output not routed");

  chk_pin14_tx: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_ASYNC_B && field[1] == CODE_SEL2)
      |=> pad_oe_o[1] && pad_out_o[1] == $past(async_b_transmit_i))
    else $error("pin 14 transmit not driven");

  chk_pin15_rx: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_ASYNC_B && field[2] == CODE_SEL2) ##1 (field[2] == CODE_SEL2)
      |=> async_b_receive_o == $past(pad_meta_reg[2], 2) && !pad_oe_o[2])
    else $error("pin 15 receive path wrong");

  chk_pin13_can: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_CAN_B && field[0] == CODE_SEL2)
      |=> can_b_receive_o == $past(pad_sync_reg[0]) && !pad_oe_o[0])
    else $error("pin 13 CAN receive path wrong");

  chk_sync_bidir: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_SYNC_B && field[2] == CODE_SEL3)
      |=> pad_oe_o[2] == $past(sync_b_oe_i[2]) && sync_b_in_o[2] == $past(pad_sync_reg[2]))
    else $error("pin 15 select line not bidirectional");

  chk_pin13_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_SYNC_B && field[0] == CODE_SEL3)
      |=> pad_out_o[0] == $past(sync_b_out_i[0]) && sync_b_in_o[0] == $past(pad_sync_reg[0]))
    else $error("pin 13 sync data line wrong");

  chk_pin14_clock: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (HAS_SYNC_B && field[1] == CODE_SEL3)
      |=> pad_oe_o[1] == $past(sync_b_oe_i[1]) && trip_zone_in_o[1] == IDLE_INPUT)
    else $error("pin 14 sync clock line wrong");

endmodule

// ### verilog/pin_mux_pkg.sv
package pin_mux_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] MUX_SELECT_OFS = 8'h00;
  localparam logic [7:0] MUX_CONFIG_OFS = 8'h04;
  localparam logic [31:0] MUX_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Field layout: pin n at bits 2n+1..2n
  localparam int FIELD_W = 2;
  localparam int FIELD_COUNT = 16;
  localparam int PIN15_LSB = 30;
  localparam int PIN14_LSB = 28;
  localparam int PIN13_LSB = 26;
  localparam int ROUTED_PINS = 3;

  // Config register: pwm_mode_setting
  localparam int PWM_MODE_LSB = 0;
  localparam int PWM_MODE_W = 2;
  localparam logic [1:0] PWM_MODE_RESET = 2'h0;
  localparam logic [1:0] PWM_MODE_TRIP = 2'h0;
  localparam logic [1:0] PWM_MODE_PWM = 2'h3;

  // Selection codes
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_SEL1 = 2'h1;
  localparam logic [1:0] CODE_SEL2 = 2'h2;
  localparam logic [1:0] CODE_SEL3 = 2'h3;

  // Level seen by a peripheral input that has no pin routed to it
  localparam logic IDLE_INPUT = 1'b1;

endpackage

// ### verilog/pin_route_cell.sv
`timescale 1ns/1ps
module pin_route_cell
  import pin_mux_pkg::*;
(
  // Selection
  input wire logic [1:0] field_i,
  input wire logic [3:0] avail_i,
  // Per-code sources
  input wire logic [3:0] src_out_i,
  input wire logic [3:0] src_oe_i,
  // Routed result
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic [3:0] sel_o
);

  always_comb
  begin
    sel_o = 4'h0;
    pad_out_o = 1'b0;
    pad_oe_o = 1'b0;
    // Reserved codes keep the pad released, the safest of undefined states
    if (avail_i[field_i])
    begin
      sel_o[field_i] = 1'b1;
      pad_out_o = src_out_i[field_i];
      pad_oe_o = src_oe_i[field_i];
    end
  end

endmodule

// ### tb/pin_far_side.sv
`timescale 1ns/1ps
module pin_far_side
(
  // Device side of the pins
  input wire logic [2:0] drv_i,
  input wire logic [2:0] drv_oe_i,
  // Board source, seen once the device lets go
  input wire logic [2:0] board_i,
  output logic [2:0] level_o
);
  assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & board_i);
endmodule

// ### tb/port_a_upper_pin_function_mux_tb_top.sv
`timescale 1ns/1ps
module port_a_upper_pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pwe = 1'b0;
  logic lvl = 1'b0;
  logic [2:0] lv;
  logic [DATA_W-1:0] rd_a;
  logic [2:0] pad_a, pad_b, out_a, out_b, oe_a, oe_b, trip_a, trip_b, sync_in, gpio_in;
  logic async_rx, can_rx;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  assign lv = {3{lvl}};
  initial forever #25 clk_i = ~clk_i;

  // Sources all follow one level so every driven path is visible on the pads
  port_a_upper_pin_function_mux DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_a),
    .protected_write_enable_i(pwe), .pad_in_i(pad_a), .pad_out_o(out_a), .pad_oe_o(oe_a),
    .gpio_out_i(lv), .gpio_oe_i(3'h5), .gpio_in_o(gpio_in), .trip_zone_in_o(trip_a),
    .pwm14_out_a_i(lvl), .pwm15_out_a_i(lvl), .pwm16_out_a_i(lvl),
    .async_b_receive_o(async_rx), .async_b_transmit_i(lvl), .can_b_receive_o(can_rx),
    .sync_b_out_i(lv), .sync_b_oe_i(3'h3), .sync_b_in_o(sync_in));
  port_a_upper_pin_function_mux #(.EXT_PWM_VARIANT(1'b1)) DUT_EXT (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(), .protected_write_enable_i(pwe), .pad_in_i(pad_b), .pad_out_o(out_b),
    .pad_oe_o(oe_b), .gpio_out_i(lv), .gpio_oe_i(3'h5), .gpio_in_o(),
    .trip_zone_in_o(trip_b), .pwm14_out_a_i(lvl), .pwm15_out_a_i(lvl), .pwm16_out_a_i(lvl),
    .async_b_receive_o(), .async_b_transmit_i(lvl), .can_b_receive_o(),
    .sync_b_out_i(lv), .sync_b_oe_i(3'h3), .sync_b_in_o());
  // Board shows the inverse, so a released pin differs from a driven one
  pin_far_side far_a (.drv_i(out_a), .drv_oe_i(oe_a), .board_i(~lv), .level_o(pad_a));
  pin_far_side far_b (.drv_i(out_b), .drv_oe_i(oe_b), .board_i(~lv), .level_o(pad_b));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic en);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    pwe <= en;
    @(posedge clk_i);
    wr_i <= 1'b0;
    pwe <= 1'b0;
  endtask

  // Read data must stand in the next cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 cmp(rd_a, exp);
    @(posedge clk_i);
    #1 cmp(rd_a, 32'h0000_0000);
  endtask

  task automatic t_regs;
    rd(MUX_SELECT_OFS, 32'h0000_0000);
    wr(MUX_SELECT_OFS, 32'hFFFF_FFFF, 1'b0);
    rd(MUX_SELECT_OFS, 32'h0000_0000);
    wr(MUX_CONFIG_OFS, 32'h0000_0003, 1'b0);
    rd(MUX_CONFIG_OFS, 32'h0000_0000);
    wr(8'h10, 32'h1234_5678, 1'b1);
    rd(8'h10, 32'h0000_0000);
    rd(MUX_SELECT_OFS, 32'h0000_0000);
    wr(MUX_SELECT_OFS, 32'h5A3C_96E1, 1'b1);
    rd(MUX_SELECT_OFS, 32'h5A3C_96E1);
  endtask

  // Every code of all three pins, mode settings 0 and 3, both pin levels
  task automatic t_route;
    logic [2:0] e_oe, e2_oe, e2_trip, pl, pl2;
    for (int m = 0; m < 4; m += 3)
    begin
      wr(MUX_CONFIG_OFS, 32'(m), 1'b1);
      for (int c = 0; c < 4; c++)
      begin
        wr(MUX_SELECT_OFS, {c[1:0], c[1:0], c[1:0], 26'h000_0000}, 1'b1);
        for (int l = 0; l < 2; l++)
        begin
          @(posedge clk_i);
          lvl <= l[0];
          repeat (4) @(posedge clk_i);
          #1;
          e_oe = (c == 0) ? 3'h5 : (c == 2) ? 3'h2 : (c == 3) ? 3'h3 : 3'h0;
          e2_oe = (c == 1 && m == 3) ? 3'h7 : e_oe;
          pl = e_oe ~^ lv;
          pl2 = e2_oe ~^ lv;
          e2_trip = (c == 1 && m == 0) ? pl2 : 3'h7;
          cmp({oe_a, out_a & oe_a, trip_a, async_rx, can_rx, sync_in, gpio_in},
            {e_oe, e_oe & lv, (c == 1) ? pl : 3'h7, (c == 2) ? pl[2] : 1'b1,
            (c == 2) ? pl[0] : 1'b1, (c == 3) ? pl : 3'h7, pl});
          cmp({oe_b, out_b & oe_b, trip_b}, {e2_oe, e2_oe & lv, e2_trip});
        end
      end
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run needs about 140 cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_route();
    end_of_test();
  end
endmodule
